// ---- src/i2cm_regs.svh ----
// register offsets, field positions, reset values and timing counts of the two-wire master
`ifndef I2CM_REGS_SVH
`define I2CM_REGS_SVH

`define I2CM_STAT_OFS 12'h100
`define I2CM_IEN_OFS 12'h104
`define I2CM_CTL_OFS 12'h110

`define I2CM_DONE_BIT 8
`define I2CM_ACK_RCVD_BIT 25
`define I2CM_HW_SEQ_BIT 7
`define I2CM_RATE_BIT 6
`define I2CM_NO_STOP_BIT 5
`define I2CM_NO_START_BIT 4
`define I2CM_STRETCH_BIT 3
`define I2CM_COUNT_ACK_BIT 2
`define I2CM_SCL_OVR_BIT 1
`define I2CM_SDA_OVR_BIT 0

`define I2CM_CTL_RST 8'h03
`define I2CM_IEN_RST 24'h000000

// core clock and serial rates, rates in units of 0.1 Hz
`define I2CM_CLK_HZ 125000000
`define I2CM_RATE_SLOW_HZX10 992000
`define I2CM_RATE_FAST_HZX10 3968000
// quarter bit period in core cycles, rounded up so the line never runs too fast
`define I2CM_QTR_SLOW ((`I2CM_CLK_HZ * 10 + 4 * `I2CM_RATE_SLOW_HZX10 - 1) / (4 * `I2CM_RATE_SLOW_HZX10))
`define I2CM_QTR_FAST ((`I2CM_CLK_HZ * 10 + 4 * `I2CM_RATE_FAST_HZX10 - 1) / (4 * `I2CM_RATE_FAST_HZX10))

`endif

// ---- src/i2cm_pkg.sv ----
// types of the two-wire master: sequencer states and state records
package i2cm_pkg;

  typedef enum logic [1:0] {st_idle, st_start, st_bit, st_stop} i2cm_state_e;

  typedef struct packed {
    i2cm_state_e st;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [1:0] byten;
    logic [1:0] nbytes;
    logic rd;
    logic [7:0] sh;
    logic ack_ok;
    logic [7:0] db0;
    logic [7:0] db1;
    logic [7:0] db2;
    logic [7:0] ctl;
    logic [23:0] mask;
    logic done;
    logic ack_rcvd;
    logic rw_saved;
    logic scl_lo;
    logic sda_lo;
    logic inta;
    logic [31:0] rdata;
  } i2cm_core_s;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] out;
  } i2cm_sync_s;

  typedef struct packed {
    logic [8:0] cnt;
  } i2cm_tick_s;

endpackage

// ---- src/i2cm_sync.sv ----
// three-stage synchroniser for the two line inputs
`timescale 1ns/100ps
`default_nettype none
module i2cm_sync (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [1:0] din,
  output logic [1:0] dout
);
  i2cm_pkg::i2cm_sync_s s_q;
  i2cm_pkg::i2cm_sync_s s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.s1 = din;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    // a level is taken only once stages two and three agree
    s_d.out = ((s_q.s2 ~^ s_q.s3) & s_q.s3) | ((s_q.s2 ^ s_q.s3) & s_q.out);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      s_q <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3, out: 2'h3};
    else if (ce)
      s_q <= s_d;
  end

  assign dout = s_q.out;
endmodule
`default_nettype wire

// ---- src/i2cm_tick.sv ----
// quarter bit timer with rate select and stall for clock stretching
`timescale 1ns/100ps
`default_nettype none
`include "i2cm_regs.svh"
module i2cm_tick (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic run,
  input wire logic stall,
  input wire logic fast,
  output logic tick
);
  i2cm_pkg::i2cm_tick_s s_q;
  i2cm_pkg::i2cm_tick_s s_d;
  logic [8:0] lim;

  assign lim = fast ? 9'(`I2CM_QTR_FAST) : 9'(`I2CM_QTR_SLOW);
  assign tick = run && !stall && (s_q.cnt == lim - 9'h001);

  always_comb
  begin
    s_d = s_q;
    if (!run || tick)
      s_d.cnt = 9'h000;
    else if (!stall)
      s_d.cnt = s_q.cnt + 9'h001;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      s_q <= '{cnt: 9'h000};
    else if (ce)
      s_q <= s_d;
  end
endmodule
`default_nettype wire

// ---- src/i2cm_top.sv ----
// two-wire master with hardware sequencer, bit-bang override and interrupt enable mask
`timescale 1ns/100ps
`default_nettype none
`include "i2cm_regs.svh"
module i2cm_top (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [11:0] reg_addr,
  input wire logic [3:0] reg_be,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic inta_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_oe,
  output logic sda_o
);
  localparam i2cm_pkg::i2cm_core_s CORE_RST = '{
    st: i2cm_pkg::st_idle,
    ctl: `I2CM_CTL_RST,
    mask: `I2CM_IEN_RST,
    default: '0
  };

  i2cm_pkg::i2cm_core_s s_q;
  i2cm_pkg::i2cm_core_s s_d;
  logic [1:0] pins;
  logic scl_in;
  logic sda_in;
  logic tick;
  logic stall;
  logic wr_ctl;
  logic wr_ien;
  logic wr_stat;
  logic go;
  logic done_set;
  logic [7:0] nb0;
  logic [7:0] nctl;
  logic ack_drive;
  logic [23:0] stat_now;

  i2cm_sync u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .din({scl_i, sda_i}),
    .dout(pins)
  );

  assign scl_in = pins[1];
  assign sda_in = pins[0];

  // a released clock that still reads low is the slave stretching it
  assign stall = s_q.ctl[`I2CM_STRETCH_BIT] && !s_q.scl_lo && !scl_in
    && s_q.st != i2cm_pkg::st_idle;

  i2cm_tick u_tick (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .run(s_q.st != i2cm_pkg::st_idle),
    .stall(stall),
    .fast(s_q.ctl[`I2CM_RATE_BIT]),
    .tick(tick)
  );

  assign wr_ctl = reg_wr && reg_addr == `I2CM_CTL_OFS;
  assign wr_ien = reg_wr && reg_addr == `I2CM_IEN_OFS;
  assign wr_stat = reg_wr && reg_addr == `I2CM_STAT_OFS;
  assign nb0 = reg_be[3] ? reg_wdata[31:24] : s_q.db0;
  assign nctl = reg_be[0] ? reg_wdata[7:0] : s_q.ctl;
  // start only from idle; a write while busy just updates the fields
  assign go = wr_ctl && reg_be[0] && reg_wdata[`I2CM_HW_SEQ_BIT]
    && s_q.st == i2cm_pkg::st_idle;
  // master ACK only on a single-byte read without START and byte-count 1
  assign ack_drive = s_q.ctl[`I2CM_NO_START_BIT] && s_q.ctl[`I2CM_COUNT_ACK_BIT];

  always_comb
  begin
    s_d = s_q;
    done_set = 1'b0;
    // register writes, byte lane by byte lane
    if (wr_ien)
    begin
      if (reg_be[0])
        s_d.mask[7:0] = reg_wdata[7:0];
      if (reg_be[1])
        s_d.mask[15:8] = reg_wdata[15:8];
      if (reg_be[2])
        s_d.mask[23:16] = reg_wdata[23:16];
    end
    if (wr_stat && reg_be[1] && reg_wdata[`I2CM_DONE_BIT])
      s_d.done = 1'b0;
    if (wr_ctl)
    begin
      s_d.db0 = nb0;
      if (reg_be[2])
        s_d.db1 = reg_wdata[23:16];
      if (reg_be[1])
        s_d.db2 = reg_wdata[15:8];
      s_d.ctl = nctl;
    end
    if (go)
    begin
      s_d.q = 2'h0;
      s_d.bitn = 4'h0;
      s_d.byten = 2'h0;
      s_d.ack_ok = 1'b1;
      if (!nctl[`I2CM_NO_START_BIT])
      begin
        s_d.st = i2cm_pkg::st_start;
        s_d.rw_saved = nb0[0];
        // a read is the address byte then one received byte
        if (nb0[0])
          s_d.nbytes = 2'h2;
        else
          s_d.nbytes = nctl[`I2CM_COUNT_ACK_BIT] ? 2'h3 : 2'h2;
      end
      else
      begin
        s_d.st = i2cm_pkg::st_bit;
        s_d.nbytes = 2'h1;
        s_d.rd = s_q.rw_saved;
        s_d.sh = nb0;
      end
    end
    else if (tick)
    begin
      s_d.q = s_q.q + 2'h1;
      case (s_q.st)
        i2cm_pkg::st_start:
        begin
          case (s_q.q)
            2'h0: s_d.sda_lo = 1'b0;
            2'h1: s_d.scl_lo = 1'b0;
            2'h2: s_d.sda_lo = 1'b1;
            default:
            begin
              s_d.scl_lo = 1'b1;
              s_d.st = i2cm_pkg::st_bit;
              s_d.rd = 1'b0;
              s_d.sh = s_q.db0;
            end
          endcase
        end
        i2cm_pkg::st_bit:
        begin
          case (s_q.q)
            2'h0:
            begin
              if (s_q.bitn == 4'h8)
                s_d.sda_lo = s_q.rd && ack_drive;
              else
                s_d.sda_lo = !s_q.rd && !s_q.sh[7];
            end
            2'h1: s_d.scl_lo = 1'b0;
            2'h2:
            begin
              if (s_q.bitn != 4'h8)
                s_d.sh = {s_q.sh[6:0], sda_in};
              else if (!s_q.rd && sda_in)
                s_d.ack_ok = 1'b0;
            end
            default:
            begin
              s_d.scl_lo = 1'b1;
              if (s_q.bitn != 4'h8)
                s_d.bitn = s_q.bitn + 4'h1;
              else
              begin
                s_d.bitn = 4'h0;
                if (!s_q.ack_ok || s_q.byten + 2'h1 == s_q.nbytes)
                begin
                  if (s_q.rd)
                    s_d.db2 = s_q.sh;
                  s_d.sda_lo = 1'b0;
                  if (s_q.ctl[`I2CM_NO_STOP_BIT])
                  begin
                    // clock stays pulled low until the next transaction
                    s_d.st = i2cm_pkg::st_idle;
                    done_set = 1'b1;
                  end
                  else
                    s_d.st = i2cm_pkg::st_stop;
                end
                else
                begin
                  s_d.byten = s_q.byten + 2'h1;
                  s_d.rd = s_q.rw_saved;
                  s_d.sh = (s_q.byten == 2'h0) ? s_q.db1 : s_q.db2;
                end
              end
            end
          endcase
        end
        i2cm_pkg::st_stop:
        begin
          case (s_q.q)
            2'h0: s_d.sda_lo = 1'b1;
            2'h1: s_d.scl_lo = 1'b0;
            2'h2: s_d.sda_lo = 1'b0;
            default:
            begin
              s_d.st = i2cm_pkg::st_idle;
              done_set = 1'b1;
            end
          endcase
        end
        default: s_d.q = 2'h0;
      endcase
    end
    // the set comes after the clear so a finish in the clearing cycle is kept
    if (done_set)
    begin
      s_d.done = 1'b1;
      s_d.ack_rcvd = s_q.ack_ok;
    end
    // only the done bit feeds the interrupt; the ack received bit at 25 lies outside the 24-bit mask
    s_d.inta = |({15'h0000, s_d.done, 8'h00} & s_d.mask);
    if (reg_rd)
    begin
      case (reg_addr)
        `I2CM_STAT_OFS: s_d.rdata = {6'h00, s_q.ack_rcvd, 16'h0000, s_q.done, 8'h00};
        `I2CM_IEN_OFS: s_d.rdata = {8'h00, s_q.mask};
        `I2CM_CTL_OFS: s_d.rdata = {s_q.db0, s_q.db1, s_q.db2, s_q.ctl[7:2], scl_in, sda_in};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
  end

  assign stat_now = {15'h0000, s_q.done, 8'h00};

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      s_q <= CORE_RST;
    else if (ce)
      s_q <= s_d;
  end

  // open drain: the sequencer only drives the lines in hardware mode
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = !s_q.ctl[`I2CM_SCL_OVR_BIT]
    || (s_q.ctl[`I2CM_HW_SEQ_BIT] && s_q.scl_lo);
  assign sda_oe = !s_q.ctl[`I2CM_SDA_OVR_BIT]
    || (s_q.ctl[`I2CM_HW_SEQ_BIT] && s_q.sda_lo);
  assign inta_o = s_q.inta;
  assign reg_rdata = s_q.rdata;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  irq_level_a: assert property (inta_o == |(stat_now & s_q.mask))
    else $error("interrupt level does not match enabled status");

  unmask_now_a: assert property (ce && wr_ien && reg_be[1] && reg_wdata[8] && s_q.done
    |=> inta_o)
    else $error("unmasking a pending done did not raise the interrupt");

  done_w1c_a: assert property (ce && wr_stat && reg_be[1] && reg_wdata[8] && !done_set
    |=> !s_q.done)
    else $error("write one did not clear done");

  stop_done_a: assert property (ce && s_q.st == i2cm_pkg::st_stop
    && s_d.st == i2cm_pkg::st_idle |=> s_q.done && !scl_oe)
    else $error("done not set after stop");

  sw_mode_idle_a: assert property (ce && wr_ctl && reg_be[0] && !reg_wdata[7]
    && s_q.st == i2cm_pkg::st_idle |=> s_q.st == i2cm_pkg::st_idle)
    else $error("transaction started in software mode");

  hw_start_a: assert property (ce && go && !reg_wdata[4]
    |=> s_q.st == i2cm_pkg::st_start ##0 s_q.rw_saved == $past(nb0[0]))
    else $error("hardware write did not begin with start");

  nostop_hold_a: assert property (ce && s_q.st == i2cm_pkg::st_bit
    && s_d.st == i2cm_pkg::st_idle && s_q.ctl[`I2CM_NO_STOP_BIT] |=> scl_oe)
    else $error("clock not held low after no-stop transaction");

  pin_readback_a: assert property (ce && reg_rd && reg_addr == `I2CM_CTL_OFS
    |=> s_q.rdata[1:0] == $past(pins))
    else $error("override bits do not read the pins");

  ovr_force_a: assert property (!s_q.ctl[1] && !s_q.ctl[0] |-> scl_oe && sda_oe)
    else $error("override low does not drive the lines");

  nack_clear_a: assert property (ce && done_set && !s_q.ack_ok |=> !s_q.ack_rcvd)
    else $error("ack received set after a nack");

  done_ok_c: cover property (ce && done_set && s_q.ack_ok);
  read_c: cover property (s_q.st == i2cm_pkg::st_bit && s_q.rd && tick);
  stretch_c: cover property (stall ##1 stall);
endmodule
`default_nettype wire

// ---- verif/i2cm_slave_model.sv ----
// behavioural two-wire slave: stores written bytes, answers one read byte
`timescale 1ns/100ps
`default_nettype none
module i2cm_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack,
  input wire logic [7:0] rd_byte,
  output logic sda_oe,
  output int stops
);
  logic [7:0] sh;
  logic act, tx, tx_nx, first;
  int n;
  logic [7:0] got[$];
  initial
  begin
    sda_oe = 1'b0;
    act = 1'b0;
    stops = 0;
  end
  // start: data falls while clock is high
  always @(negedge sda)
    if (scl)
    begin
      {act, first, tx, tx_nx} = 4'b1100;
      n = 0;
    end
  always @(posedge sda)
    if (scl && act)
    begin
      act = 1'b0;
      sda_oe = 1'b0;
      stops++;
    end
  always @(posedge scl)
    if (act)
    begin
      // a master nack ends the read; keep off the line so the stop can pass
      if (tx && n == 8)
        tx_nx = !sda;
      if (n < 8)
        sh = {sh[6:0], sda};
      n++;
    end
  // only change the data line while the clock is low
  always @(negedge scl)
    if (act)
    begin
      if (n == 8 && !tx)
      begin
        got.push_back(sh);
        if (first)
          tx_nx = sh[0];
        sda_oe = !nack;
      end
      else if (n == 9)
      begin
        n = 0;
        first = 1'b0;
        tx = tx_nx;
        sda_oe = tx && !rd_byte[7];
      end
      else if (tx && n > 0 && n < 8)
        sda_oe = !rd_byte[7 - n];
      else
        sda_oe = 1'b0;
    end
endmodule
`default_nettype wire

// ---- verif/tb_i2c_master_with_irq_mask.sv ----
// self-checking bench of the two-wire master and its interrupt mask
`timescale 1ns/100ps
`default_nettype none
`include "i2cm_regs.svh"
module tb_i2c_master_with_irq_mask;
  logic clk_sys, rstn, reg_wr, reg_rd, rd_pend, scl_oe, sda_oe, s_oe, inta_o, nack;
  logic [11:0] reg_addr;
  logic [3:0] reg_be;
  logic [31:0] reg_wdata, reg_rdata, lfsr, m;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  logic [7:0] w0, b1, b2, rb;
  int bad_count, checks_done, cyc, last_rise, per, stops;
  wire logic scl_ln;
  wire logic sda_ln;
  // open-drain lines with pull-ups
  assign scl_ln = !scl_oe;
  assign sda_ln = !(sda_oe | s_oe);
  i2cm_top DUT (.clk_sys(clk_sys), .rstn(rstn), .ce(1'b1), .reg_addr(reg_addr),
    .reg_be(reg_be), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .inta_o(inta_o), .scl_i(scl_ln), .scl_o(), .scl_oe(scl_oe),
    .sda_i(sda_ln), .sda_oe(sda_oe), .sda_o());
  i2cm_slave_model S (.scl(scl_ln), .sda(sda_ln), .nack(nack), .rd_byte(rb),
    .sda_oe(s_oe), .stops(stops));
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // read results land one cycle after the strobe; compare them there
  always @(posedge clk_sys)
  begin
    cyc++;
    if (rd_pend)
    begin
      m = mq.pop_front();
      chk("rdata", eq.pop_front() & m, reg_rdata & m);
    end
    rd_pend = reg_rd;
    if (cyc == 95000)
    begin
      bad_count++;
      close_out();
    end
  end
  always @(posedge scl_ln)
  begin
    per = cyc - last_rise;
    last_rise = cyc;
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_be = be;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] k);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    eq.push_back(e);
    mq.push_back(k);
    @(negedge clk_sys);
    reg_rd = 1'b0;
  endtask
  task automatic irq(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be,
    input logic e);
    wr(a, d, be);
    repeat (2) @(negedge clk_sys);
    chk("inta", {31'h0, e}, {31'h0, inta_o});
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic rnd;
    lfsr = lfsr_next(lfsr);
    {w0, b1, b2} = lfsr[23:0];
    w0[0] = 1'b0;
    rb = b2 ^ 8'hA5;
  endtask
  // clears done first so a later wait can use the interrupt line
  task automatic xfer(input logic [31:0] c, input logic [31:0] e);
    int s0;
    int i;
    wr(`I2CM_STAT_OFS, 32'h100, 4'hF);
    s0 = stops;
    i = 0;
    wr(`I2CM_CTL_OFS, c, 4'hF);
    while (stops == s0 && inta_o !== 1'b1 && i < 40000)
    begin
      @(negedge clk_sys);
      i++;
    end
    // a transaction that never ends is a failure, not a silent pass
    if (i >= 40000)
      bad_count++;
    // done trails the stop by a quarter; the slow quarter covers both rates
    repeat (`I2CM_QTR_SLOW + 4) @(negedge clk_sys);
    rd(`I2CM_STAT_OFS, e, 32'h02000100);
  endtask
  task automatic gotchk(input logic [23:0] v, input int n);
    for (int i = 0; i < n; i++)
      chk("wire byte", {24'h0, v[23 - 8 * i -: 8]}, {24'h0, S.got.pop_front()});
    chk("byte count", 32'h0, 32'(S.got.size()));
  endtask
  initial
  begin
    {reg_wr, reg_rd, rd_pend, nack, rstn} = 5'h00;
    reg_addr = 12'h000;
    reg_be = 4'h0;
    reg_wdata = 32'h0;
    lfsr = 32'hC13F2DFF;
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
    rd(`I2CM_CTL_OFS, 32'h3, 32'hFF);
    rd(`I2CM_IEN_OFS, 32'h0, 32'hFFFFFFFF);
    rd(12'h108, 32'h0, 32'hFFFFFFFF);
    wr(`I2CM_CTL_OFS, 32'h2, 4'hF);
    repeat (6) @(negedge clk_sys);
    chk("sda_oe", 32'h1, {31'h0, sda_oe});
    rd(`I2CM_CTL_OFS, 32'h2, 32'h3);
    wr(`I2CM_CTL_OFS, 32'h1, 4'hF);
    repeat (6) @(negedge clk_sys);
    chk("scl_oe", 32'h1, {31'h0, scl_oe});
    rd(`I2CM_CTL_OFS, 32'h1, 32'h3);
    // overrides stay released in hardware mode
    wr(`I2CM_CTL_OFS, 32'h3, 4'hF);
    rnd();
    xfer({w0, b1, b2, 8'hC7}, 32'h02000100);
    gotchk({w0, b1, b2}, 3);
    chk("period", 32'(4 * `I2CM_QTR_FAST), 32'(per));
    chk("inta", 32'h0, {31'h0, inta_o});
    irq(`I2CM_IEN_OFS, 32'h100, 4'hF, 1'b1);
    irq(`I2CM_IEN_OFS, 32'h0, 4'h1, 1'b1);
    irq(`I2CM_STAT_OFS, 32'h100, 4'hF, 1'b0);
    rnd();
    xfer({w0, b1, b2, 8'h83}, 32'h02000100);
    gotchk({w0, b1, 8'h0}, 2);
    chk("period", 32'(4 * `I2CM_QTR_SLOW), 32'(per));
    rnd();
    w0[0] = 1'b1;
    xfer({w0, b1, b2, 8'hC3}, 32'h02000100);
    gotchk({w0, 16'h0}, 1);
    rd(`I2CM_CTL_OFS, {16'h0, rb, 8'h0}, 32'hFF00);
    rnd();
    nack = 1'b1;
    xfer({w0, b1, b2, 8'hC3}, 32'h00000100);
    gotchk({w0, 16'h0}, 1);
    nack = 1'b0;
    rnd();
    xfer({w0, b1, b2, 8'hE3}, 32'h02000100);
    chk("scl_oe", 32'h1, {31'h0, scl_oe});
    gotchk({w0, b1, 8'h0}, 2);
    // stretch enabled: the sync latency on each release must only slow the clock
    xfer({b1, w0, b2, 8'hDF}, 32'h02000100);
    gotchk({b1, 16'h0}, 1);
    close_out();
  end
endmodule
`default_nettype wire
